// File: mde_regs.vh
`ifndef MDE_REGS_VH
`define MDE_REGS_VH

// ****************************************
// apb register offsets
// ****************************************
`define MDE_OFS_CTRL 8'h00
`define MDE_OFS_STATUS 8'h04
`define MDE_OFS_FADDR 8'h08
`define MDE_OFS_FDATA 8'h0c

// ****************************************
// field positions
// ****************************************
`define MDE_CTRL_RUN 0
`define MDE_CTRL_PSA_T0 1
`define MDE_ST_C 0
`define MDE_ST_DC 1
`define MDE_ST_Z 2
`define MDE_ST_TO 3
`define MDE_ST_PD 4
`define MDE_ST_SLEEP 5

// ****************************************
// reset values
// ****************************************
`define MDE_CTRL_RST 2'h0
`define MDE_TO_RST 1'b1
`define MDE_PD_RST 1'b1

// ****************************************
// special file addresses
// ****************************************
`define MDE_FA_TIMER0 7'h01
`define MDE_FA_PORT 7'h05

// ****************************************
// timing: pclk periods per instruction cycle
// ****************************************
`define MDE_PHASES 4
`define MDE_PHASE_LAST 2'h3

// ****************************************
// alu operations
// ****************************************
`define MDE_ALU_ADD 4'h0
`define MDE_ALU_SUB 4'h1
`define MDE_ALU_AND 4'h2
`define MDE_ALU_OR 4'h3
`define MDE_ALU_XOR 4'h4
`define MDE_ALU_PASS 4'h5
`define MDE_ALU_COM 4'h6
`define MDE_ALU_INC 4'h7
`define MDE_ALU_DEC 4'h8
`define MDE_ALU_RL 4'h9
`define MDE_ALU_RR 4'ha
`define MDE_ALU_SWAP 4'hb
`define MDE_ALU_CLR 4'hc

`endif

// File: mde_alu.v
`timescale 1ns/100ps
`default_nettype none
`include "mde_regs.vh"

module mde_alu (
   input wire [3:0] op,
   input wire [7:0] acc,
   input wire [7:0] opnd,
   input wire carry_in,
   output reg [7:0] res,
   output reg carry_out,
   output reg half_carry_out,
   output wire zero_out
);
   reg [8:0] sum;
   reg [4:0] low;

   always @* begin
      sum = 9'h000;
      low = 5'h00;
      res = 8'h00;
      carry_out = carry_in;
      half_carry_out = 1'b0;
      case (op)
         `MDE_ALU_ADD: begin
            sum = {1'b0, acc} + {1'b0, opnd};
            low = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
            res = sum[7:0];
            carry_out = sum[8];
            half_carry_out = low[4];
         end
         // carry set means no borrow
         `MDE_ALU_SUB: begin
            sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
            low = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
            res = sum[7:0];
            carry_out = sum[8];
            half_carry_out = low[4];
         end
         `MDE_ALU_AND: res = acc & opnd;
         `MDE_ALU_OR: res = acc | opnd;
         `MDE_ALU_XOR: res = acc ^ opnd;
         `MDE_ALU_PASS: res = opnd;
         `MDE_ALU_COM: res = ~opnd;
         `MDE_ALU_INC: res = opnd + 8'h01;
         `MDE_ALU_DEC: res = opnd - 8'h01;
         `MDE_ALU_RL: begin
            res = {opnd[6:0], carry_in};
            carry_out = opnd[7];
         end
         `MDE_ALU_RR: begin
            res = {carry_in, opnd[7:1]};
            carry_out = opnd[0];
         end
         `MDE_ALU_SWAP: res = {opnd[3:0], opnd[7:4]};
         `MDE_ALU_CLR: res = 8'h00;
         default: res = opnd;
      endcase
   end

   assign zero_out = (res == 8'h00);
endmodule // mde_alu

`default_nettype wire

// File: mde_core.v
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mde_regs.vh"

module mde_core #(
   parameter PC_W = 13,
   parameter STACK_DEPTH = 8,
   parameter SP_W = 3
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg [PC_W-1:0] prog_addr,
   input wire [13:0] prog_data,
   input wire [7:0] port_pin_in,
   output reg [7:0] port_latch_out,
   output reg prescaler_clear,
   output reg watchdog_clear,
   output reg standby_req
);
   // ****************************************
   // state
   // ****************************************
   reg [7:0] file_mem [0:127];
   reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
   reg [SP_W-1:0] sp_ff;
   reg [7:0] acc_ff;
   reg [13:0] instr_ff;
   reg [1:0] phase_ff;
   reg flush_ff;
   reg c_ff, dc_ff, z_ff, to_ff, pd_ff, sleep_ff;
   reg run_ff, psa_t0_ff;
   reg [6:0] faddr_ff;
   reg [7:0] pin_meta_ff, pin_sync_ff;

   // ****************************************
   // decode
   // ****************************************
   wire [1:0] cls = instr_ff[13:12];
   wire [3:0] nib = instr_ff[11:8];
   wire dst_file = instr_ff[7];
   wire [2:0] bit_idx = instr_ff[9:7];
   wire [6:0] fa = instr_ff[6:0];
   wire [7:0] lit = instr_ff[7:0];
   wire [7:0] bit_mask = 8'h01 << bit_idx;
   wire [7:0] file_rd = (fa == `MDE_FA_PORT) ? pin_sync_ff : file_mem[fa];
   wire active = run_ff & ~sleep_ff;
   wire exec = active & (phase_ff == `MDE_PHASE_LAST) & ~flush_ff;

   reg [3:0] alu_op;
   reg [7:0] alu_b;
   reg wr_acc, wr_file, upd_c, upd_dc, upd_z;
   reg do_skip, do_jump, do_push, do_pop, do_sleep, do_wdt;
   wire [7:0] alu_res;
   wire alu_c, alu_dc, alu_z;

   mde_alu u_alu (
      .op(alu_op),
      .acc(acc_ff),
      .opnd(alu_b),
      .carry_in(c_ff),
      .res(alu_res),
      .carry_out(alu_c),
      .half_carry_out(alu_dc),
      .zero_out(alu_z)
   );

   always @* begin
      alu_op = `MDE_ALU_PASS;
      alu_b = file_rd;
      wr_acc = 1'b0;
      wr_file = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      do_skip = 1'b0;
      do_jump = 1'b0;
      do_push = 1'b0;
      do_pop = 1'b0;
      do_sleep = 1'b0;
      do_wdt = 1'b0;
      case (cls)
         2'b00: begin
            wr_acc = ~dst_file;
            wr_file = dst_file;
            case (nib)
               4'b0000: begin
                  wr_acc = 1'b0;
                  wr_file = 1'b0;
                  if (dst_file) begin
                     alu_op = `MDE_ALU_PASS;
                     alu_b = acc_ff;
                     wr_file = 1'b1;
                  end else if (instr_ff[7:0] == 8'h08 || instr_ff[7:0] == 8'h09) begin
                     do_pop = 1'b1;
                  end else if (instr_ff[7:0] == 8'h63) begin
                     do_sleep = 1'b1;
                  end else if (instr_ff[7:0] == 8'h64) begin
                     do_wdt = 1'b1;
                  end
               end
               4'b0001: begin
                  alu_op = `MDE_ALU_CLR;
                  upd_z = 1'b1;
               end
               4'b0010: begin
                  alu_op = `MDE_ALU_SUB;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  upd_z = 1'b1;
               end
               4'b0011: begin
                  alu_op = `MDE_ALU_DEC;
                  upd_z = 1'b1;
               end
               4'b0100: begin
                  alu_op = `MDE_ALU_OR;
                  upd_z = 1'b1;
               end
               4'b0101: begin
                  alu_op = `MDE_ALU_AND;
                  upd_z = 1'b1;
               end
               4'b0110: begin
                  alu_op = `MDE_ALU_XOR;
                  upd_z = 1'b1;
               end
               4'b0111: begin
                  alu_op = `MDE_ALU_ADD;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  upd_z = 1'b1;
               end
               4'b1000: upd_z = 1'b1;
               4'b1001: begin
                  alu_op = `MDE_ALU_COM;
                  upd_z = 1'b1;
               end
               4'b1010: begin
                  alu_op = `MDE_ALU_INC;
                  upd_z = 1'b1;
               end
               4'b1011: begin
                  alu_op = `MDE_ALU_DEC;
                  do_skip = alu_z;
               end
               4'b1100: begin
                  alu_op = `MDE_ALU_RR;
                  upd_c = 1'b1;
               end
               4'b1101: begin
                  alu_op = `MDE_ALU_RL;
                  upd_c = 1'b1;
               end
               4'b1110: alu_op = `MDE_ALU_SWAP;
               default: begin
                  alu_op = `MDE_ALU_INC;
                  do_skip = alu_z;
               end
            endcase
         end
         2'b01: begin
            case (nib[3:2])
               2'b00: begin
                  alu_b = file_rd & ~bit_mask;
                  wr_file = 1'b1;
               end
               2'b01: begin
                  alu_b = file_rd | bit_mask;
                  wr_file = 1'b1;
               end
               2'b10: do_skip = ~|(file_rd & bit_mask);
               default: do_skip = |(file_rd & bit_mask);
            endcase
         end
         2'b10: begin
            do_jump = 1'b1;
            do_push = ~instr_ff[11];
         end
         default: begin
            alu_b = lit;
            wr_acc = 1'b1;
            casez (nib)
               4'b00??: alu_op = `MDE_ALU_PASS;
               4'b01??: do_pop = 1'b1;
               4'b1000: begin
                  alu_op = `MDE_ALU_OR;
                  upd_z = 1'b1;
               end
               4'b1001: begin
                  alu_op = `MDE_ALU_AND;
                  upd_z = 1'b1;
               end
               4'b1010: begin
                  alu_op = `MDE_ALU_XOR;
                  upd_z = 1'b1;
               end
               4'b110?: begin
                  alu_op = `MDE_ALU_SUB;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  upd_z = 1'b1;
               end
               4'b111?: begin
                  alu_op = `MDE_ALU_ADD;
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  upd_z = 1'b1;
               end
               default: wr_acc = 1'b0;
            endcase
         end
      endcase
   end

   // ****************************************
   // pin synchroniser
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_ff <= 8'h00;
         pin_sync_ff <= 8'h00;
      end else begin
         pin_meta_ff <= port_pin_in;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // ****************************************
   // instruction sequencer
   // ****************************************
   wire [PC_W-1:0] pc_inc = prog_addr + {{(PC_W-1){1'b0}}, 1'b1};
   wire [PC_W-1:0] pc_skip = prog_addr + {{(PC_W-2){1'b0}}, 2'b10};
   wire [PC_W-1:0] jmp_tgt = {prog_addr[PC_W-1:11], instr_ff[10:0]};
   wire [SP_W-1:0] sp_dec = sp_ff - {{(SP_W-1){1'b0}}, 1'b1};
   wire apb_wr = psel & penable & pready & pwrite;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= 2'h0;
         instr_ff <= 14'h0000;
         flush_ff <= 1'b0;
         prog_addr <= {PC_W{1'b0}};
         sp_ff <= {SP_W{1'b0}};
         acc_ff <= 8'h00;
         c_ff <= 1'b0;
         dc_ff <= 1'b0;
         z_ff <= 1'b0;
         to_ff <= `MDE_TO_RST;
         pd_ff <= `MDE_PD_RST;
         sleep_ff <= 1'b0;
         port_latch_out <= 8'h00;
         prescaler_clear <= 1'b0;
         watchdog_clear <= 1'b0;
         standby_req <= 1'b0;
      end else begin
         prescaler_clear <= 1'b0;
         watchdog_clear <= 1'b0;
         standby_req <= 1'b0;
         if (active) begin
            phase_ff <= phase_ff + 2'h1;
         end else begin
            phase_ff <= 2'h0;
         end
         if (active && phase_ff == 2'h0) begin
            instr_ff <= prog_data;
         end
         if (active && phase_ff == `MDE_PHASE_LAST && flush_ff) begin
            flush_ff <= 1'b0;
         end
         if (exec) begin
            prog_addr <= pc_inc;
            if (wr_acc) begin
               acc_ff <= alu_res;
            end
            if (wr_file) begin
               file_mem[fa] <= alu_res;
               if (fa == `MDE_FA_PORT) begin
                  port_latch_out <= alu_res;
               end
               if (fa == `MDE_FA_TIMER0 && psa_t0_ff) begin
                  prescaler_clear <= 1'b1;
               end
            end
            if (upd_c) begin
               c_ff <= alu_c;
            end
            if (upd_dc) begin
               dc_ff <= alu_dc;
            end
            if (upd_z) begin
               z_ff <= alu_z;
            end
            // taken test or pc load adds nop
            if (do_skip) begin
               prog_addr <= pc_skip;
               flush_ff <= 1'b1;
            end
            if (do_jump) begin
               prog_addr <= jmp_tgt;
               flush_ff <= 1'b1;
            end
            if (do_push) begin
               stack_mem[sp_ff] <= pc_inc;
               sp_ff <= sp_ff + {{(SP_W-1){1'b0}}, 1'b1};
            end
            if (do_pop) begin
               prog_addr <= stack_mem[sp_dec];
               sp_ff <= sp_dec;
               flush_ff <= 1'b1;
            end
            // to set, pd cleared on standby
            if (do_sleep) begin
               to_ff <= 1'b1;
               pd_ff <= 1'b0;
               sleep_ff <= 1'b1;
               standby_req <= 1'b1;
            end
            if (do_wdt) begin
               to_ff <= 1'b1;
               pd_ff <= 1'b1;
               watchdog_clear <= 1'b1;
            end
         end else if (!active && apb_wr && paddr == `MDE_OFS_FDATA) begin
            // debug write only while halted, so no clash with execution
            file_mem[faddr_ff] <= pwdata[7:0];
            if (faddr_ff == `MDE_FA_PORT) begin
               port_latch_out <= pwdata[7:0];
            end
         end
         // wake only by software writing the control word
         if (apb_wr && paddr == `MDE_OFS_CTRL && !exec) begin
            sleep_ff <= 1'b0;
         end
      end
   end

   // ****************************************
   // apb slave
   // ****************************************
   localparam [1:0] CTRL_RST = `MDE_CTRL_RST;
   reg [31:0] rd_mux;
   reg hit;

   always @* begin
      rd_mux = 32'h0000_0000;
      hit = 1'b1;
      case (paddr)
         `MDE_OFS_CTRL: rd_mux = {30'h0000_0000, psa_t0_ff, run_ff};
         `MDE_OFS_STATUS: begin
            rd_mux[`MDE_ST_C] = c_ff;
            rd_mux[`MDE_ST_DC] = dc_ff;
            rd_mux[`MDE_ST_Z] = z_ff;
            rd_mux[`MDE_ST_TO] = to_ff;
            rd_mux[`MDE_ST_PD] = pd_ff;
            rd_mux[`MDE_ST_SLEEP] = sleep_ff;
            rd_mux[15:8] = acc_ff;
            rd_mux[16+PC_W-1:16] = prog_addr;
         end
         `MDE_OFS_FADDR: rd_mux = {25'h000_0000, faddr_ff};
         `MDE_OFS_FDATA: rd_mux = {24'h00_0000, file_mem[faddr_ff]};
         default: hit = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         run_ff <= CTRL_RST[`MDE_CTRL_RUN];
         psa_t0_ff <= CTRL_RST[`MDE_CTRL_PSA_T0];
         faddr_ff <= 7'h00;
      end else begin
         // answer one cycle after setup; pready drops after the access edge
         pready <= psel & ~penable & ~pready;
         // error stands with pready only, one cycle
         pslverr <= psel & ~penable & ~pready & ~hit;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
         if (apb_wr && paddr == `MDE_OFS_CTRL) begin
            run_ff <= pwdata[`MDE_CTRL_RUN];
            psa_t0_ff <= pwdata[`MDE_CTRL_PSA_T0];
         end
         if (apb_wr && paddr == `MDE_OFS_FADDR) begin
            faddr_ff <= pwdata[6:0];
         end
      end
   end
endmodule // mde_core

`default_nettype wire

// File: mde_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// port checker
// ****************
module mde_monitor #(
   parameter PC_W = 13
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [PC_W-1:0] prog_addr,
   input wire logic [7:0] port_latch_out,
   input wire logic prescaler_clear,
   input wire logic watchdog_clear,
   input wire logic standby_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   setup_ready_a: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   ready_once_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   // error only for unmapped words, judged on the held address
   slverr_map_a: assert property (psel && !penable |=>
      pslverr == (paddr > 8'h0c || paddr[1:0] != 2'h0))
      else $error("slave error wrong");
   slverr_ready_a: assert property (pslverr |-> pready && psel && penable)
      else $error("slave error outside access");
   pc_stands_a: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
      else $error("pc moved inside a cycle");
   dummy_cycle_a: assert property ($changed(prog_addr) &&
      prog_addr != $past(prog_addr) + 1'b1 |=> $stable(prog_addr)[*7])
      else $error("no dummy cycle after pc jump");
   wdt_pulse_a: assert property (watchdog_clear |->
      $changed(prog_addr) ##1 (!watchdog_clear)[*3])
      else $error("watchdog pulse wrong");
   standby_pulse_a: assert property (standby_req |=> (!standby_req)[*3])
      else $error("standby pulse wrong");
   psc_clear_a: assert property (prescaler_clear |->
      $changed(prog_addr) ##1 !prescaler_clear)
      else $error("prescaler clear off cycle");
   // the latch moves only on an executed write or a bus write
   port_write_a: assert property ($changed(port_latch_out) |->
      $changed(prog_addr) || ($past(pready) && $past(pwrite)))
      else $error("port latch changed alone");
endmodule // mde_monitor
`default_nettype wire

// File: mde_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// program memory
// ****************
module mde_prog_mem (
   input wire logic [12:0] addr,
   output var logic [13:0] data
);
   logic [13:0] mem [0:31];
   // past the image word 0 comes back inverted, a clean nop only if word 0 is all ones
   assign data = (addr < 13'h20) ? mem[addr[4:0]] : ~mem[0];
endmodule // mde_prog_mem
`default_nettype wire

// File: mcu_instruction_decode_exec_test.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_decode_exec_test;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
   logic [7:0] paddr = 8'h0, port_pin_in = 8'h0, port_latch_out;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic pready, pslverr, prescaler_clear, watchdog_clear, standby_req;
   logic [12:0] prog_addr;
   logic [13:0] prog_data;
   logic [13:0] pg [$];
   int fails = 0, total_checks = 0, n_wdt, n_stb, n_psc;
   mde_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
      .port_pin_in(port_pin_in), .port_latch_out(port_latch_out),
      .prescaler_clear(prescaler_clear), .watchdog_clear(watchdog_clear),
      .standby_req(standby_req));
   mde_prog_mem pm_u (.addr(prog_addr), .data(prog_data));
   always #12.5 pclk = ~pclk;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_wdt <= 0;
         n_stb <= 0;
         n_psc <= 0;
      end else begin
         n_wdt <= n_wdt + (watchdog_clear === 1'h1);
         n_stb <= n_stb + (standby_req === 1'h1);
         n_psc <= n_psc + (prescaler_clear === 1'h1);
      end
   end
   // ****************
   // helpers
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      check(n < 20, 1'h1);
      rv = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'h0, a, 32'h0);
   endtask
   task automatic set_file(input logic [6:0] fa, input logic [7:0] v);
      wr(8'h08, {25'h0, fa});
      wr(8'h0c, {24'h0, v});
   endtask
   task automatic get_file(input logic [6:0] fa);
      wr(8'h08, {25'h0, fa});
      rd(8'h0c);
   endtask
   // program goes in while reset holds the core
   task automatic rst();
      @(posedge pclk);
      presetn <= 1'h0;
      for (int i = 0; i < 32; i++)
         pm_u.mem[i] = (i < pg.size()) ? pg[i] : 14'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
   endtask
   task automatic go(input logic psa, input logic [12:0] tgt);
      int n;
      n = 0;
      wr(8'h00, {30'h0, psa, 1'h1});
      while (prog_addr !== tgt && n < 500) begin
         @(posedge pclk);
         n++;
      end
      check(prog_addr, tgt);
      repeat (12) @(posedge pclk);
   endtask
   function automatic logic [13:0] enc(input int op, input logic d, input logic [6:0] fa,
         input logic [7:0] k);
      logic [3:0] nib [6] = '{4'h7, 4'h5, 4'h4, 4'h6, 4'hd, 4'hc};
      logic [5:0] lit [5] = '{6'h3e, 6'h3c, 6'h39, 6'h38, 6'h3a};
      return (op < 6) ? {2'h0, nib[op], d, fa} : {lit[op - 6], k};
   endfunction
   // result in 7:0, then carry, half carry, zero
   function automatic logic [10:0] calc(input int op, input logic [7:0] a, f,
         input logic cin);
      logic [8:0] s;
      logic [7:0] r;
      logic c, h;
      c = cin;
      h = cin;
      s = a + f;
      r = s[7:0];
      case (op)
         0, 6: begin
            c = s[8];
            h = (a[3:0] + f[3:0]) > 5'h0f;
         end
         7: begin
            r = f - a;
            c = f >= a;
            h = f[3:0] >= a[3:0];
         end
         1, 8: r = a & f;
         2, 9: r = a | f;
         3, 10: r = a ^ f;
         4: begin
            r = {f[6:0], cin};
            c = f[7];
         end
         default: begin
            r = {cin, f[7:1]};
            c = f[0];
         end
      endcase
      return {(op == 4 || op == 5) ? cin : (r == 8'h0), h, c, r};
   endfunction
   // ****************
   // scenarios
   // ****************
   initial begin
      logic [7:0] a, f;
      logic [10:0] e;
      logic cin, d;
      logic [6:0] fa;
      logic [7:0] sk [4] = '{8'h00, 8'h00, 8'h58, 8'h30};
      int op, n;
      void'($urandom(43198));
      rst();
      rd(8'h00);
      check(rv, 32'h0);
      rd(8'h04);
      check(rv[4:3], 2'h3);
      rd(8'h10);
      check({err, rv}, {1'h1, 32'h0});
      wr(8'h14, 32'hffff_ffff);
      check(err, 1'h1);
      // flags preset to the carry-in, then one random operation
      for (int i = 0; i < 40; i++) begin
         op = $urandom_range(10, 0);
         a = $urandom;
         f = $urandom;
         cin = $urandom;
         d = $urandom;
         fa = (i == 0) ? 7'h7f : 7'h20 + 7'($urandom_range(95, 0));
         pg = '{14'h30ff, {6'h3e, 7'h0, cin}, {6'h30, a}, enc(op, d, fa, f), 14'h2804};
         rst();
         set_file(fa, f);
         go(1'h0, 13'h4);
         e = calc(op, a, f, cin);
         rd(8'h04);
         check({rv[15:8], rv[2:0]}, {(op > 5 || !d ? e[7:0] : a), e[10:8]});
         get_file(fa);
         check(rv[7:0], (op < 6 && d) ? e[7:0] : f);
      end
      pg = '{14'h200a, 14'h2008, 14'h200c, 14'h280e, 14'h3804, 14'h0, 14'h0, 14'h0,
         14'h3801, 14'h0008, 14'h3480, 14'h0, 14'h3802, 14'h0009, 14'h3808, 14'h280f};
      rst();
      go(1'h0, 13'hf);
      rd(8'h04);
      check(rv[15:8], 8'h8b);
      // skipped words would set marker bits in file 0x24
      pg = '{14'h30ff, 14'h3e01, 14'h0ba1, 14'h1424, 14'h0fa2, 14'h14a4, 14'h1823,
         14'h1524, 14'h1ca3, 14'h15a4, 14'h18a3, 14'h1624, 14'h1c23, 14'h16a4, 14'h10a3,
         14'h280f};
      rst();
      for (int i = 0; i < 4; i++)
         set_file(7'h21 + 7'(i), (i == 0) ? 8'h01 : (i == 1) ? 8'hff : (i == 2) ? 8'h5a : 8'h00);
      go(1'h0, 13'hf);
      rd(8'h04);
      check({rv[15:8], rv[2:0]}, 11'h007);
      for (int i = 0; i < 4; i++) begin
         get_file(7'h21 + 7'(i));
         check(rv[7:0], sk[i]);
      end
      for (int s = 0; s < 2; s++) begin
         pg = '{14'h3000, 14'h0485, 14'h0781, 14'h0701, 14'h2804};
         rst();
         set_file(7'h05, 8'hff);
         @(posedge pclk);
         port_pin_in <= $urandom;
         check(port_latch_out, 8'hff);
         go(s[0], 13'h4);
         check(port_latch_out, port_pin_in);
         check(n_psc, s);
      end
      pg = '{14'h0063, 14'h0064, 14'h2802};
      rst();
      wr(8'h00, 32'h1);
      n = 0;
      while (n_stb == 0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      repeat (12) @(posedge pclk);
      rd(8'h04);
      check({rv[5], n_wdt[30:0]}, {1'h1, 31'h0});
      go(1'h0, 13'h2);
      rd(8'h04);
      check(rv[5:3], 3'h3);
      check({n_wdt[15:0], n_stb[15:0]}, 32'h0001_0001);
      report_and_stop();
   end
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule // mcu_instruction_decode_exec_test
bind mde_core mde_monitor #(.PC_W(PC_W)) mon_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .prog_addr(prog_addr), .port_latch_out(port_latch_out),
   .prescaler_clear(prescaler_clear), .watchdog_clear(watchdog_clear),
   .standby_req(standby_req));
`default_nettype wire
